/* File: hw/bwd_regs.svh */
`ifndef BWD_REGS_SVH
`define BWD_REGS_SVH
// ****************************************
// Band layout and numeric formats
// ****************************************
`define BWD_NUM_BANDS 9
`define BWD_BIN_HZ 400
`define BWD_BINS_PER_BAND 4
`define BWD_Q8_ONE 16'h0100
`define BWD_LOG10_OF_2_Q8 7'h4D
// Offset added to every filterbank mean and maximum (1.6 in Q8)
`define BWD_OFFSET_Q8 16'h019A
// log10(8 * scale^2) in Q8 for 8, 16, 32 and 48 kHz input
`define BWD_SCALE_8K_Q8 16'h04CC
`define BWD_SCALE_16K_Q8 16'h04CC
`define BWD_SCALE_32K_Q8 16'h04CC
`define BWD_SCALE_48K_Q8 16'h04CB
// Noise gate for the long-term means, 30 dB in Q8
`define BWD_NOISE_GATE_Q8 16'h1E00
// ****************************************
// Counters and selection
// ****************************************
`define BWD_CNT_MIN 7'h00
`define BWD_CNT_MAX 7'h64
`define BWD_CNT_RESET 7'h00
`define BWD_CNT_INC 7'h02
`define BWD_CNT_DEC 7'h01
`define BWD_SEL_HI 7'h5A
`define BWD_SEL_LO 7'h0A
`define BWD_THR_MEAN_FBK 16'h0100
`define BWD_THR_MAX_FBK 16'h0180
`define BWD_THR_MEAN_DCT 16'h0200
`define BWD_THR_MAX_DCT 16'h0280
// ****************************************
// Bitrate limits, in units of 0.1 kbps
// ****************************************
`define BWD_RATE_NB_MAX 16'h00F4
`define BWD_RATE_SWB_MIN 16'h0060
`define BWD_RATE_FB_MIN 16'h00A4
`endif

/* File: hw/bwd_pkg.sv */
package bwd_pkg;
  typedef enum logic [1:0] {
    BWD_NARROW_BAND,
    BWD_WIDE_BAND,
    BWD_SUPER_WIDE_BAND,
    BWD_FULL_BAND
  } bwd_class_t;
  typedef enum logic [1:0] {
    BWD_FS_8K,
    BWD_FS_16K,
    BWD_FS_32K,
    BWD_FS_48K
  } bwd_rate_t;
  typedef enum {
    BWD_IDLE,
    BWD_LOG,
    BWD_WAIT,
    BWD_CALC,
    BWD_COUNT,
    BWD_SELECT,
    BWD_DONE
  } bwd_state_t;
  typedef logic signed [15:0] bwd_q8_t;
  localparam int BWD_BAND_START [0:8] = '{3, 11, 14, 23, 27, 31, 35, 42, 46};
endpackage : bwd_pkg

/* File: hw/bwd_log_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface bwd_log_if;
  logic req;
  logic [33:0] arg;
  logic ack;
  logic [15:0] res;
  modport client (output req, output arg, input ack, input res);
  modport server (input req, input arg, output ack, output res);
endinterface : bwd_log_if
`default_nettype wire

/* File: hw/bwd_log10.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bwd_regs.svh"
module bwd_log10
  import bwd_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  bwd_log_if.server lg
);
  // ****************************************
  // Log2 by leading one, then scale to log10
  // ****************************************
  logic [5:0] msb;
  logic [33:0] norm;
  logic [13:0] log2_q8;
  logic [20:0] prod;
  always_comb begin
    msb = 6'h00;
    for (int i = 0; i < 34; i++) begin
      if (lg.arg[i]) begin
        msb = 6'(i);
      end
    end
    norm = lg.arg << (6'd33 - msb);
    // Linear fraction: under 0.09 of error in log2, well below the decision margins
    log2_q8 = {msb, norm[32:25]};
    prod = 21'(log2_q8) * 21'(`BWD_LOG10_OF_2_Q8);
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      lg.ack <= 1'b0;
      lg.res <= 16'h0000;
    end else begin
      lg.ack <= lg.req;
      lg.res <= {3'b000, prod[20:8]};
    end
  end
endmodule : bwd_log10
`default_nettype wire

/* File: hw/bwd_detector.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bwd_regs.svh"
// Contract
// - Each filterbank band sums four consecutive 400 Hz bins, spanning 1600 Hz.
// - Nine bands over bins 3-6 up to 46-49, limited by sampling rate.
// - Band energy becomes log10 of energy over eight times squared scale.
// - Means: band 0, average 1-2, average 3-6, average 7-8, plus 1.6.
// - Maxima: narrowband mean plus 1.6; else band maxima per class plus 1.6.
// - Transform mode uses windowed 320-sample DCT energies split per class.
// - Transform mode: plain log10, no scaling, no 1.6 offset.
// - One decision logic for both modes; only comparison constants differ.
// - Long-term means: 0.75 of previous plus 0.25 of current.
// - Long-term update only when active and noise above 30 dB.
// - One counter per class, stepped by comparisons in fixed order.
// - Sequential selection tests; chosen counters forced to 0 or 100.
// - Bandwidth clamped to widest class supported at the bitrate.
// - Detection runs only for sampling rates above 8 kHz.
// - Decision codes narrowband, wideband, super-wideband, fullband.
// - Transform mode when the legacy interoperable wideband mode runs.
module bwd_detector
  import bwd_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic legacy_wb_mode,
  input wire logic [1:0] rate_sel,
  input wire logic [15:0] bitrate,
  input wire logic activity_decision,
  input wire logic [15:0] noise_level,
  input wire logic bin_valid,
  input wire logic [31:0] bin_energy,
  input wire logic frame_end,
  output logic [1:0] bandwidth,
  output logic bandwidth_valid,
  output logic busy
);
  // ****************************************
  // Band accumulation
  // ****************************************
  bwd_state_t state_ff;
  logic [5:0] bin_idx_ff;
  logic [33:0] acc_ff [0:8];
  bwd_q8_t band_ff [0:8];
  logic [3:0] band_sel_ff;
  logic [3:0] nbands;
  logic mode_dct_ff;
  logic [1:0] rate_ff;
  logic taking;
  assign taking = (state_ff == BWD_IDLE) && bin_valid;
  // Number of bands that fit under the Nyquist frequency
  always_comb begin
    case (rate_ff)
      BWD_FS_16K: nbands = 4'd3;
      BWD_FS_32K: nbands = 4'd7;
      BWD_FS_48K: nbands = 4'd9;
      default: nbands = 4'd1;
    endcase
  end
  for (genvar b = 0; b < `BWD_NUM_BANDS; b++) begin : g_acc
    localparam logic [5:0] START = 6'(BWD_BAND_START[b]);
    localparam logic [5:0] STOP = 6'(BWD_BAND_START[b] + `BWD_BINS_PER_BAND - 1);
    always_ff @(posedge clock) begin
      if (reset || state_ff == BWD_DONE) begin
        acc_ff[b] <= 34'h000000000;
      end else if (taking && legacy_wb_mode && bin_idx_ff == 6'(b)) begin
        acc_ff[b] <= {2'b00, bin_energy};
      end else if (taking && !legacy_wb_mode && bin_idx_ff >= START && bin_idx_ff <= STOP) begin
        acc_ff[b] <= acc_ff[b] + {2'b00, bin_energy};
      end
    end
  end
  always_ff @(posedge clock) begin
    if (reset || state_ff == BWD_DONE) begin
      bin_idx_ff <= 6'h00;
    end else if (taking && bin_idx_ff != 6'h3F) begin
      bin_idx_ff <= bin_idx_ff + 6'h01;
    end
  end
  // Mode and rate are caught at frame end for the log and decision stages; bin intake follows legacy_wb_mode as it stands
  always_ff @(posedge clock) begin
    if (reset) begin
      mode_dct_ff <= 1'b0;
      rate_ff <= 2'b00;
    end else if (state_ff == BWD_IDLE && frame_end) begin
      mode_dct_ff <= legacy_wb_mode;
      rate_ff <= rate_sel;
    end
  end
  // ****************************************
  // Log conversion, one band at a time
  // ****************************************
  bwd_log_if lg ();
  bwd_log10 u_log (
    .clock(clock),
    .reset(reset),
    .lg(lg)
  );
  bwd_q8_t scale;
  always_comb begin
    case (rate_ff)
      BWD_FS_8K: scale = `BWD_SCALE_8K_Q8;
      BWD_FS_16K: scale = `BWD_SCALE_16K_Q8;
      BWD_FS_32K: scale = `BWD_SCALE_32K_Q8;
      default: scale = `BWD_SCALE_48K_Q8;
    endcase
  end
  assign lg.req = (state_ff == BWD_LOG);
  assign lg.arg = (acc_ff[band_sel_ff] == 34'h000000000) ? 34'h000000001 : acc_ff[band_sel_ff];
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < `BWD_NUM_BANDS; i++) begin
        band_ff[i] <= 16'sh0000;
      end
    end else if (state_ff == BWD_WAIT && lg.ack) begin
      if (mode_dct_ff) begin
        band_ff[band_sel_ff] <= lg.res;
      end else begin
        band_ff[band_sel_ff] <= lg.res - scale;
      end
    end
  end
  // ****************************************
  // Means, maxima and long-term means
  // ****************************************
  bwd_q8_t mean_ff [0:3];
  bwd_q8_t max_ff [0:3];
  bwd_q8_t lt_ff [0:2];
  bwd_q8_t ofs;
  bwd_q8_t nxt_mean [0:3];
  bwd_q8_t nxt_max [0:3];
  logic [17:0] sum4;
  assign ofs = mode_dct_ff ? 16'sh0000 : `BWD_OFFSET_Q8;
  always_comb begin
    sum4 = 18'(band_ff[3]) + 18'(band_ff[4]) + 18'(band_ff[5]) + 18'(band_ff[6]);
    nxt_mean[0] = band_ff[0] + ofs;
    nxt_mean[1] = 16'((17'(band_ff[1]) + 17'(band_ff[2])) >>> 1) + ofs;
    nxt_mean[2] = 16'($signed(sum4) >>> 2) + ofs;
    nxt_mean[3] = 16'((17'(band_ff[7]) + 17'(band_ff[8])) >>> 1) + ofs;
    nxt_max[0] = nxt_mean[0] + ofs;
    nxt_max[1] = ((band_ff[1] > band_ff[2]) ? band_ff[1] : band_ff[2]) + ofs;
    nxt_max[2] = band_ff[3];
    for (int i = 4; i < 7; i++) begin
      if (band_ff[i] > nxt_max[2]) begin
        nxt_max[2] = band_ff[i];
      end
    end
    nxt_max[2] = nxt_max[2] + ofs;
    nxt_max[3] = ((band_ff[7] > band_ff[8]) ? band_ff[7] : band_ff[8]) + ofs;
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        mean_ff[i] <= 16'sh0000;
        max_ff[i] <= 16'sh0000;
      end
    end else if (state_ff == BWD_CALC) begin
      mean_ff <= nxt_mean;
      max_ff <= nxt_max;
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < 3; i++) begin
        lt_ff[i] <= 16'sh0000;
      end
    end else if (state_ff == BWD_CALC && activity_decision
                 && $signed(noise_level) > $signed(`BWD_NOISE_GATE_Q8)) begin
      for (int i = 0; i < 3; i++) begin
        lt_ff[i] <= 16'((18'sd3 * 18'(lt_ff[i]) + 18'(nxt_mean[i])) >>> 2);
      end
    end
  end
  // ****************************************
  // Counters and sequential selection
  // ****************************************
  logic [6:0] cnt_ff [0:3];
  logic [1:0] step_ff;
  logic [1:0] sel_ff;
  bwd_q8_t thr_mean;
  bwd_q8_t thr_max;
  bwd_q8_t cls_mean;
  logic [1:0] top_cls;
  assign thr_mean = mode_dct_ff ? `BWD_THR_MEAN_DCT : `BWD_THR_MEAN_FBK;
  assign thr_max = mode_dct_ff ? `BWD_THR_MAX_DCT : `BWD_THR_MAX_FBK;
  // Fullband has no long-term mean, so its current mean stands in
  assign cls_mean = (step_ff == 2'd3) ? mean_ff[3] : lt_ff[step_ff];
  assign top_cls = (nbands == 4'd9) ? 2'd3 : (nbands == 4'd7) ? 2'd2 : 2'd1;
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        cnt_ff[i] <= `BWD_CNT_RESET;
      end
    end else if (state_ff == BWD_COUNT) begin
      if (cls_mean > thr_mean && max_ff[step_ff] > thr_max) begin
        cnt_ff[step_ff] <= (cnt_ff[step_ff] > `BWD_CNT_MAX - `BWD_CNT_INC) ?
                           `BWD_CNT_MAX : cnt_ff[step_ff] + `BWD_CNT_INC;
      end else begin
        cnt_ff[step_ff] <= (cnt_ff[step_ff] < `BWD_CNT_MIN + `BWD_CNT_DEC) ?
                           `BWD_CNT_MIN : cnt_ff[step_ff] - `BWD_CNT_DEC;
      end
    end else if (state_ff == BWD_SELECT) begin
      if (cnt_ff[step_ff] >= `BWD_SEL_HI && step_ff > sel_ff && step_ff <= top_cls) begin
        cnt_ff[step_ff] <= `BWD_CNT_MAX;
      end else if (cnt_ff[step_ff] <= `BWD_SEL_LO && step_ff != 2'd0 && step_ff <= sel_ff) begin
        cnt_ff[step_ff] <= `BWD_CNT_MIN;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      sel_ff <= 2'(BWD_NARROW_BAND);
    end else if (state_ff == BWD_SELECT) begin
      // Later tests may overwrite earlier ones within the frame
      if (cnt_ff[step_ff] >= `BWD_SEL_HI && step_ff > sel_ff && step_ff <= top_cls) begin
        sel_ff <= step_ff;
      end else if (cnt_ff[step_ff] <= `BWD_SEL_LO && step_ff != 2'd0 && step_ff <= sel_ff) begin
        sel_ff <= step_ff - 2'd1;
      end
    end else if (state_ff == BWD_DONE && sel_ff > top_cls) begin
      sel_ff <= top_cls;
    end
  end
  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= BWD_IDLE;
      band_sel_ff <= 4'h0;
      step_ff <= 2'd0;
    end else begin
      case (state_ff)
        BWD_IDLE: begin
          band_sel_ff <= 4'h0;
          if (frame_end) begin
            // 8 kHz input skips detection and reports narrowband, or wideband when bitrate is above BWD_RATE_NB_MAX
            state_ff <= (rate_sel == 2'(BWD_FS_8K)) ? BWD_DONE : BWD_LOG;
          end
        end
        BWD_LOG: state_ff <= BWD_WAIT;
        BWD_WAIT: begin
          if (lg.ack) begin
            if (band_sel_ff + 4'h1 >= nbands) begin
              state_ff <= BWD_CALC;
            end else begin
              band_sel_ff <= band_sel_ff + 4'h1;
              state_ff <= BWD_LOG;
            end
          end
        end
        BWD_CALC: begin
          step_ff <= 2'd0;
          state_ff <= BWD_COUNT;
        end
        BWD_COUNT: begin
          step_ff <= step_ff + 2'd1;
          if (step_ff == 2'd3) begin
            state_ff <= BWD_SELECT;
          end
        end
        BWD_SELECT: begin
          step_ff <= step_ff + 2'd1;
          if (step_ff == 2'd3) begin
            state_ff <= BWD_DONE;
          end
        end
        BWD_DONE: state_ff <= BWD_IDLE;
        default: state_ff <= BWD_IDLE;
      endcase
    end
  end
  // ****************************************
  // Bitrate clamp and outputs
  // ****************************************
  logic [1:0] clamped;
  logic [1:0] bw_ff;
  logic bw_valid_ff;
  logic busy_ff;
  always_comb begin
    clamped = (sel_ff > top_cls) ? top_cls : sel_ff;
    if (rate_ff == 2'(BWD_FS_8K)) begin
      clamped = 2'(BWD_NARROW_BAND);
    end
    if (clamped == 2'(BWD_FULL_BAND) && bitrate < `BWD_RATE_FB_MIN) begin
      clamped = 2'(BWD_SUPER_WIDE_BAND);
    end
    if (clamped == 2'(BWD_SUPER_WIDE_BAND) && bitrate < `BWD_RATE_SWB_MIN) begin
      clamped = 2'(BWD_WIDE_BAND);
    end
    if (clamped == 2'(BWD_NARROW_BAND) && bitrate > `BWD_RATE_NB_MAX) begin
      clamped = 2'(BWD_WIDE_BAND);
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      bw_ff <= 2'(BWD_NARROW_BAND);
      bw_valid_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      bw_valid_ff <= (state_ff == BWD_DONE);
      busy_ff <= (state_ff != BWD_IDLE) || frame_end;
      if (state_ff == BWD_DONE) begin
        bw_ff <= clamped;
      end
    end
  end
  assign bandwidth = bw_ff;
  assign bandwidth_valid = bw_valid_ff;
  assign busy = busy_ff;
endmodule : bwd_detector
`default_nettype wire

/* File: verification/bwd_detector_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module bwd_detector_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic legacy_wb_mode,
  input wire logic [1:0] rate_sel,
  input wire logic [15:0] bitrate,
  input wire logic activity_decision,
  input wire logic [15:0] noise_level,
  input wire logic bin_valid,
  input wire logic [31:0] bin_energy,
  input wire logic frame_end,
  input wire logic [1:0] bandwidth,
  input wire logic bandwidth_valid,
  input wire logic busy
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  // Frame end only counts while idle; the block drops it when busy, except in the result cycle, which is already idle
  logic go;
  assign go = frame_end && !busy;
  // ****************************************
  // Framing and latency
  // ****************************************
  a_busy_start: assert property (go |=> busy [*2])
    else $error("busy did not follow frame end");
  a_valid_pulse: assert property (bandwidth_valid |=> !bandwidth_valid)
    else $error("valid longer than one cycle");
  // Busy still shows the done cycle while the result pulse stands, then drops
  a_valid_frame: assert property (bandwidth_valid |-> busy && $past(busy) ##1 !busy)
    else $error("result outside a frame");
  a_bw_hold: assert property (!bandwidth_valid |-> $stable(bandwidth))
    else $error("bandwidth moved without valid");
  a_lat_narrow: assert property (go && rate_sel == 2'h0 |-> ##2
    bandwidth_valid && bandwidth == 2'h0) else $error("8k result wrong");
  a_lat_wide: assert property (go && rate_sel == 2'h1 |-> ##17
    bandwidth_valid && bandwidth <= 2'h1) else $error("16k result wrong");
  a_lat_super: assert property (go && rate_sel == 2'h2 |-> ##25
    bandwidth_valid && bandwidth != 2'h3) else $error("32k result wrong");
  a_lat_full: assert property (go && rate_sel == 2'h3 |-> ##29 bandwidth_valid)
    else $error("48k result late");
  // ****************************************
  // Bitrate clamp
  // ****************************************
  a_clamp_full: assert property (bandwidth_valid && $past(bitrate) < 16'h00A4 |->
    bandwidth != 2'h3) else $error("fullband below its bitrate");
  a_clamp_super: assert property (bandwidth_valid && $past(bitrate) < 16'h0060 |->
    bandwidth <= 2'h1) else $error("super-wideband below its bitrate");
  c_full: cover property (bandwidth_valid && bandwidth == 2'h3);
  c_super: cover property (bandwidth_valid && bandwidth == 2'h2);
  c_dct: cover property (go && legacy_wb_mode);
endmodule : bwd_detector_monitor
bind bwd_detector bwd_detector_monitor mon (
  .clock(clock), .reset(reset), .legacy_wb_mode(legacy_wb_mode), .rate_sel(rate_sel),
  .bitrate(bitrate), .activity_decision(activity_decision), .noise_level(noise_level),
  .bin_valid(bin_valid), .bin_energy(bin_energy), .frame_end(frame_end),
  .bandwidth(bandwidth), .bandwidth_valid(bandwidth_valid), .busy(busy)
);
`default_nettype wire

/* File: verification/bwd_front_end.sv */
`timescale 1ns/1ns
`default_nettype none
module bwd_front_end (
  input wire logic clock,
  output logic bin_valid,
  output logic [31:0] bin_energy,
  output logic frame_end
);
  initial begin
    bin_valid = 1'b0;
    bin_energy = 32'h0000_0000;
    frame_end = 1'b0;
  end
  // Idle data shows the inverse, so a stale bin can never look valid
  task automatic send_frame(input int nb, input logic [31:0] e, input int gap);
    for (int k = 0; k < nb; k++) begin
      @(posedge clock);
      bin_valid <= 1'b1;
      bin_energy <= e;
      repeat (gap) begin
        @(posedge clock);
        bin_valid <= 1'b0;
        bin_energy <= ~e;
      end
    end
    @(posedge clock);
    bin_valid <= 1'b0;
    bin_energy <= ~e;
    frame_end <= 1'b1;
    @(posedge clock);
    frame_end <= 1'b0;
  endtask : send_frame
endmodule : bwd_front_end
`default_nettype wire

/* File: verification/audio_bandwidth_detector_test.sv */
`timescale 1ns/1ns
`default_nettype none
module audio_bandwidth_detector_test;
  logic clock, reset, legacy_wb_mode, activity_decision, bin_valid, frame_end;
  logic bandwidth_valid, busy;
  logic [1:0] rate_sel, bandwidth;
  logic [15:0] bitrate, noise_level;
  logic [31:0] bin_energy;
  int n_fail = 0;
  int checks_done = 0;
  int lat;
  // Edges from frame end to result: bands x 2, one calc, four count, four select, done; 8 kHz goes straight to done
  localparam int lat_tab [0:3] = '{1, 16, 24, 28};
  localparam logic [15:0] rate_steps [0:3] = '{16'h00A4, 16'h00A3, 16'h0060, 16'h005F};
  localparam logic [1:0] clamp_exp [0:3] = '{2'h3, 2'h2, 2'h2, 2'h1};
  bwd_detector dut (
    .clock(clock), .reset(reset), .legacy_wb_mode(legacy_wb_mode), .rate_sel(rate_sel),
    .bitrate(bitrate), .activity_decision(activity_decision), .noise_level(noise_level),
    .bin_valid(bin_valid), .bin_energy(bin_energy), .frame_end(frame_end),
    .bandwidth(bandwidth), .bandwidth_valid(bandwidth_valid), .busy(busy)
  );
  bwd_front_end fe (
    .clock(clock), .bin_valid(bin_valid), .bin_energy(bin_energy), .frame_end(frame_end)
  );
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic do_reset();
    @(posedge clock);
    reset <= 1'b1;
    repeat (11) @(posedge clock);
    reset <= 1'b0;
  endtask : do_reset
  // Counts edges from the one that takes frame end to the result
  task automatic frame(input int nb, input logic [31:0] e, input int gap);
    fe.send_frame(nb, e, gap);
    lat = 0;
    while (bandwidth_valid !== 1'b1 && lat < 40) begin
      @(posedge clock);
      #1;
      lat++;
    end
  endtask : frame
  // Counters step by two, so 46 frames are enough to cross the upper mark
  task automatic scen(input logic [1:0] r, input logic lg, input logic act,
      input logic [15:0] nz, input int nb, input logic [31:0] e, input logic [1:0] exp);
    do_reset();
    @(posedge clock);
    rate_sel <= r;
    legacy_wb_mode <= lg;
    activity_decision <= act;
    noise_level <= nz;
    bitrate <= 16'h00C8;
    repeat (46) frame(nb, e, 0);
    check("latency", 8'(lat_tab[r]), 8'(lat));
    check("bandwidth", {6'h00, exp}, {6'h00, bandwidth});
  endtask : scen
  initial begin : watchdog
    #300000;
    n_fail++;
    give_verdict();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    reset = 1'b1;
    legacy_wb_mode = 1'b0;
    rate_sel = 2'h0;
    bitrate = 16'h00C8;
    activity_decision = 1'b1;
    noise_level = 16'h2000;
    do_reset();
    @(posedge clock);
    #1;
    check("reset outputs", 8'h00, {4'h0, bandwidth, bandwidth_valid, busy});
    for (int r = 0; r < 4; r++) begin
      @(posedge clock);
      rate_sel <= 2'(r);
      frame(50, 32'h1000_0000, r);
      check("single latency", 8'(lat_tab[r]), 8'(lat));
      check("single bandwidth", 8'h00, {6'h00, bandwidth});
    end
    scen(2'h3, 1'b0, 1'b1, 16'h2000, 50, 32'h1000_0000, 2'h3);
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      bitrate <= rate_steps[k];
      frame(50, 32'h1000_0000, 0);
      check("clamped", {6'h00, clamp_exp[k]}, {6'h00, bandwidth});
    end
    scen(2'h2, 1'b0, 1'b1, 16'h2001, 50, 32'h1000_0000, 2'h2);
    scen(2'h2, 1'b0, 1'b1, 16'h1E00, 50, 32'h1000_0000, 2'h0);
    scen(2'h2, 1'b0, 1'b0, 16'h2000, 50, 32'h1000_0000, 2'h0);
    scen(2'h0, 1'b0, 1'b1, 16'h2000, 50, 32'h1000_0000, 2'h0);
    scen(2'h3, 1'b1, 1'b1, 16'h2000, 9, 32'h4000_0000, 2'h3);
    scen(2'h3, 1'b1, 1'b1, 16'h2000, 9, 32'h0000_00FB, 2'h0);
    give_verdict();
  end
endmodule : audio_bandwidth_detector_test
`default_nettype wire
